// ==== src/wake_pkg.sv ====
// constants for the wake pattern and remote-wake detector
package wake_pkg;
  localparam int          NUM_FILTERS      = 4;
  localparam int          MASK_BITS        = 31;
  localparam int          ADDR_BYTES       = 6;
  localparam int          SYNC_BYTES       = 6;
  localparam int          ADDR_REPEATS     = 16;
  localparam logic [7:0]  MIN_OFFSET       = 8'h0C;
  localparam logic [15:0] CRC16_POLY       = 16'h8005;
  localparam logic [15:0] CRC16_INIT       = 16'hFFFF;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_STATION_LO  = 12'h004;
  localparam logic [11:0] ADDR_STATION_HI  = 12'h008;
  localparam logic [11:0] ADDR_FILTER_BASE = 12'h010;
  localparam logic [11:0] ADDR_FILTER_LAST = 12'h02C;
  // wake_ctrl_status fields
  localparam int          BIT_PATTERN_EN   = 0;
  localparam int          BIT_REMOTE_EN    = 1;
  localparam int          BIT_PATTERN_RX   = 2;
  localparam int          BIT_REMOTE_RX    = 3;
  localparam int          BIT_IRQ_SEL      = 4;
  localparam int          BIT_EVENT_SEL    = 5;
  localparam int          BIT_STANDBY      = 6;
  localparam int          BIT_NORMAL_RX    = 7;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  // filter command fields
  localparam int          CMD_ENABLE_BIT   = 0;
  localparam int          CMD_MCAST_BIT    = 3;
  // filter table word layout: words 0..3 masks, 4 commands, 5 offsets, 6..7 crc
  localparam int          TABLE_WORDS      = 8;
  localparam int          WORD_COMMAND     = 4;
  localparam int          WORD_OFFSET      = 5;
  localparam int          WORD_CRC_LO      = 6;
  localparam int          WORD_CRC_HI      = 7;
  typedef enum logic [1:0] {
    RW_HUNT = 2'b00,
    RW_SYNC = 2'b01,
    RW_ADDR = 2'b11,
    RW_DONE = 2'b10
  } remote_state_e;
endpackage

// ==== src/wake_pattern_detector.sv ====
// wake pattern CRC filters and remote-wake packet detector with APB registers
// Functional notes
// - filter offset is 8 bits; software keeps it at 12 or more.
// - byte position zero is the first destination address byte.
// - equal stored CRC-16 and computed masked CRC means wake frame.
// - remote-wake enable enters detection and blocks normal reception.
// - remote-wake detection can drive interrupt or power event output.
// - remote-wake detection sets the remote-wake received status bit.
// - clearing remote-wake enable resumes normal reception.
// - only own or broadcast destination, plus multicast, are examined.
// - after the address fields search for six bytes of all ones.
// - sixteen back-to-back station address copies must follow sync.
// - a broken address run restarts the sync search.
// - the sync and copies may sit anywhere in the frame.
// - standby enables both detectors; full power uses enable bits.
// - pattern enable blocks normal reception; match sets received bit.
// - mask bit j feeds byte at offset plus j into filter CRC.
// - command bit 0 enables filter; bit 3 picks multicast or unicast.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module wake_pattern_detector (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_SOF,
  input  wire logic        RX_EOF,
  input  wire logic        STANDBY,
  output logic             NORMAL_RX_EN,
  output logic             HOST_IRQ,
  output logic             POWER_EVENT_OUT
);
  localparam int NF = wake_pkg::NUM_FILTERS;
  localparam int MB = wake_pkg::MASK_BITS;
  // last value of the run counter, reached on the final byte of the final copy
  localparam int RUN_LAST = wake_pkg::ADDR_REPEATS * wake_pkg::ADDR_BYTES - 1;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[15] ^ d[i])
        r = {r[14:0], 1'b0} ^ wake_pkg::CRC16_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction

  logic [31:0] ctrl_reg;
  logic [47:0] station_reg;
  logic [31:0] table_reg [wake_pkg::TABLE_WORDS];
  logic [15:0] crc_reg [NF];
  logic [NF-1:0] done_reg;
  logic [7:0]  pos_reg;
  logic        dest_ok_reg;
  logic        mcast_reg;
  logic [47:0] dest_reg;
  wake_pkg::remote_state_e rw_state_reg;
  logic [2:0]  sync_cnt_reg;
  logic [2:0]  byte_cnt_reg;
  logic [4:0]  rep_cnt_reg;

  // apb decode
  wire         apb_access = PSEL && PENABLE;
  wire         apb_write  = apb_access && PWRITE;
  wire         hit_ctrl   = PADDR == wake_pkg::ADDR_CTRL_STATUS;
  wire         hit_st_lo  = PADDR == wake_pkg::ADDR_STATION_LO;
  wire         hit_st_hi  = PADDR == wake_pkg::ADDR_STATION_HI;
  wire         hit_table  = PADDR >= wake_pkg::ADDR_FILTER_BASE &&
                            PADDR <= wake_pkg::ADDR_FILTER_LAST && PADDR[1:0] == 2'b00;
  wire [2:0]   table_idx  = 3'((PADDR - wake_pkg::ADDR_FILTER_BASE) >> 2);
  wire         hit_any    = hit_ctrl || hit_st_lo || hit_st_hi || hit_table;

  // modes
  wire pattern_on = ctrl_reg[wake_pkg::BIT_PATTERN_EN] || STANDBY;
  wire remote_on  = ctrl_reg[wake_pkg::BIT_REMOTE_EN] || STANDBY;

  // frame byte bookkeeping; position 0 is first destination byte
  wire         rx_byte  = RX_VALID;
  wire [7:0]   pos_now  = RX_SOF ? 8'h00 : pos_reg;
  wire [47:0]  dest_now = {dest_reg[39:0], RX_DATA};
  wire         dest_fin = rx_byte && pos_now == 8'(wake_pkg::ADDR_BYTES - 1);
  wire         bcast    = dest_now == {48{1'b1}};
  wire         own      = dest_now == station_reg;
  // pattern filters
  logic [NF-1:0] pat_match;
  logic [15:0]   crc_next [NF];
  logic [NF-1:0] done_next;
  // crc words packed so that filter f's expected value sits at bits 16f
  wire [63:0]    crc_words = {table_reg[wake_pkg::WORD_CRC_HI], table_reg[wake_pkg::WORD_CRC_LO]};
  always_comb begin
    for (int f = 0; f < NF; f++) begin
      logic [7:0] off;
      logic [7:0] rel;
      logic [3:0] cmd;
      logic       in_win;
      logic       last;
      logic [15:0] c0;
      off    = table_reg[wake_pkg::WORD_OFFSET][8*f +: 8];
      cmd    = table_reg[wake_pkg::WORD_COMMAND][8*f +: 4];
      rel    = pos_now - off;
      in_win = pos_now >= off && rel < 8'(MB);
      c0     = RX_SOF ? wake_pkg::CRC16_INIT : crc_reg[f];
      crc_next[f] = c0;
      if (rx_byte && in_win && table_reg[f][rel[4:0]])
        crc_next[f] = crc16_byte(c0, RX_DATA);
      last = rx_byte && in_win && (table_reg[f][30:0] >> (rel[4:0] + 5'd1)) == 31'h0;
      done_next[f] = RX_SOF ? 1'b0 : done_reg[f];
      pat_match[f] = 1'b0;
      if (last && !done_next[f]) begin
        done_next[f] = 1'b1;
        pat_match[f] = pattern_on && cmd[wake_pkg::CMD_ENABLE_BIT] && dest_ok_reg &&
                       (cmd[wake_pkg::CMD_MCAST_BIT] == mcast_reg) &&
                       crc_next[f] == crc_words[16*f +: 16];
      end
    end
  end
  wire pattern_hit = |pat_match;

  // remote-wake byte scanner
  wire [2:0]  addr_sel  = 3'(wake_pkg::ADDR_BYTES - 1) - byte_cnt_reg;
  wire [7:0]  want_byte = station_reg[8*addr_sel +: 8];
  wire        past_hdr  = pos_now >= 8'(2 * wake_pkg::ADDR_BYTES);
  wire        is_ff     = RX_DATA == 8'hFF;
  wire        scan      = rx_byte && remote_on && dest_ok_reg && past_hdr;
  wire        remote_hit = scan && rw_state_reg == wake_pkg::RW_ADDR &&
                           RX_DATA == want_byte && byte_cnt_reg == 3'(wake_pkg::ADDR_BYTES - 1) &&
                           rep_cnt_reg == 5'(wake_pkg::ADDR_REPEATS - 1);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pos_reg     <= 8'h00;
      dest_reg    <= 48'h0;
      dest_ok_reg <= 1'b0;
      mcast_reg   <= 1'b0;
      done_reg    <= '0;
      for (int f = 0; f < NF; f++)
        crc_reg[f] <= wake_pkg::CRC16_INIT;
    end else if (rx_byte) begin
      pos_reg  <= (pos_now == 8'hFF) ? pos_now : pos_now + 8'h01;  // saturates on long frames
      dest_reg <= dest_now;
      done_reg <= done_next;
      for (int f = 0; f < NF; f++)
        crc_reg[f] <= crc_next[f];
      if (RX_SOF)
        dest_ok_reg <= 1'b0;
      if (dest_fin) begin
        dest_ok_reg <= own || bcast || dest_now[40];
        mcast_reg   <= dest_now[40] && !bcast;
      end
    end
  end

  // restart on break: a failing byte may itself begin a new sync run
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rw_state_reg <= wake_pkg::RW_HUNT;
      sync_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      rep_cnt_reg  <= 5'h0;
    end else if (rx_byte && (RX_SOF || RX_EOF)) begin
      rw_state_reg <= wake_pkg::RW_HUNT;
      sync_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      rep_cnt_reg  <= 5'h0;
    end else if (scan) begin
      case (rw_state_reg)
        wake_pkg::RW_HUNT, wake_pkg::RW_SYNC: begin
          sync_cnt_reg <= is_ff ? sync_cnt_reg + 3'h1 : 3'h0;
          rw_state_reg <= is_ff ? wake_pkg::RW_SYNC : wake_pkg::RW_HUNT;
          if (is_ff && sync_cnt_reg == 3'(wake_pkg::SYNC_BYTES - 1)) begin
            rw_state_reg <= wake_pkg::RW_ADDR;
            byte_cnt_reg <= 3'h0;
            rep_cnt_reg  <= 5'h0;
          end
        end
        wake_pkg::RW_ADDR: begin
          if (RX_DATA != want_byte) begin
            rw_state_reg <= is_ff ? wake_pkg::RW_SYNC : wake_pkg::RW_HUNT;
            sync_cnt_reg <= is_ff ? 3'h1 : 3'h0;
          end else if (byte_cnt_reg == 3'(wake_pkg::ADDR_BYTES - 1)) begin
            byte_cnt_reg <= 3'h0;
            rep_cnt_reg  <= rep_cnt_reg + 5'h1;
            if (remote_hit)
              rw_state_reg <= wake_pkg::RW_DONE;
          end else begin
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
          end
        end
        wake_pkg::RW_DONE: rw_state_reg <= wake_pkg::RW_DONE;
        default: rw_state_reg <= wake_pkg::RW_HUNT;
      endcase
    end
  end

  // separate count of matching bytes since the sync run; lets the checks
  // catch a copy counter that miscounts without trusting it
  logic [6:0] run_len_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_len_reg <= 7'h00;
    end else if (rx_byte && (RX_SOF || RX_EOF)) begin
      run_len_reg <= 7'h00;
    end else if (scan) begin
      if (rw_state_reg == wake_pkg::RW_ADDR && RX_DATA == want_byte)
        run_len_reg <= run_len_reg + 7'h01;
      else
        run_len_reg <= 7'h00;
    end
  end

  // registers; hardware set wins over software clear
  wire wr_ctrl = apb_write && hit_ctrl;
  wire clr_pat = wr_ctrl && PWDATA[wake_pkg::BIT_PATTERN_RX];
  wire clr_rem = wr_ctrl && PWDATA[wake_pkg::BIT_REMOTE_RX];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg    <= wake_pkg::CTRL_RESET;
      station_reg <= 48'h0;
      for (int w = 0; w < wake_pkg::TABLE_WORDS; w++)
        table_reg[w] <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[wake_pkg::BIT_PATTERN_EN] <= PWDATA[wake_pkg::BIT_PATTERN_EN];
        ctrl_reg[wake_pkg::BIT_REMOTE_EN]  <= PWDATA[wake_pkg::BIT_REMOTE_EN];
        ctrl_reg[wake_pkg::BIT_IRQ_SEL]    <= PWDATA[wake_pkg::BIT_IRQ_SEL];
        ctrl_reg[wake_pkg::BIT_EVENT_SEL]  <= PWDATA[wake_pkg::BIT_EVENT_SEL];
      end
      ctrl_reg[wake_pkg::BIT_PATTERN_RX] <= pattern_hit ||
        (ctrl_reg[wake_pkg::BIT_PATTERN_RX] && !clr_pat);
      ctrl_reg[wake_pkg::BIT_REMOTE_RX] <= remote_hit ||
        (ctrl_reg[wake_pkg::BIT_REMOTE_RX] && !clr_rem);
      if (apb_write && hit_st_lo)
        station_reg[31:0] <= PWDATA;
      if (apb_write && hit_st_hi)
        station_reg[47:32] <= PWDATA[15:0];
      if (apb_write && hit_table)
        table_reg[table_idx] <= {1'b0, PWDATA[30:0]} | (table_idx > 3'd3 ? PWDATA & 32'h8000_0000 : 32'h0);
    end
  end

  wire any_rx = ctrl_reg[wake_pkg::BIT_PATTERN_RX] || ctrl_reg[wake_pkg::BIT_REMOTE_RX];
  assign HOST_IRQ        = any_rx && ctrl_reg[wake_pkg::BIT_IRQ_SEL];
  assign POWER_EVENT_OUT = any_rx && ctrl_reg[wake_pkg::BIT_EVENT_SEL];
  assign NORMAL_RX_EN    = !pattern_on && !remote_on;

  logic [31:0] status_word;
  always_comb begin
    status_word = ctrl_reg;
    status_word[wake_pkg::BIT_STANDBY]   = STANDBY;
    status_word[wake_pkg::BIT_NORMAL_RX] = NORMAL_RX_EN;
  end
  wire [31:0] rd_mux = hit_ctrl  ? status_word :
                       hit_st_lo ? station_reg[31:0] :
                       hit_st_hi ? {16'h0, station_reg[47:32]} :
                       hit_table ? table_reg[table_idx] : 32'h0;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      PRDATA <= 32'h0;
    else if (PSEL && !PENABLE && !PWRITE)
      PRDATA <= rd_mux;
  end
  assign PREADY  = 1'b1;
  assign PSLVERR = apb_access && !hit_any;

  // status and request checks
  chk_remote_sets_status: assert property (@(posedge CLK) disable iff (!RST_N)
    remote_hit
    |=> ctrl_reg[wake_pkg::BIT_REMOTE_RX])
    else $error("remote hit lost");
  chk_pattern_sets_status: assert property (@(posedge CLK) disable iff (!RST_N)
    pattern_hit
    |=> ctrl_reg[wake_pkg::BIT_PATTERN_RX])
    else $error("pattern hit lost");
  chk_status_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
    ctrl_reg[wake_pkg::BIT_REMOTE_RX] && !clr_rem
    |=> ctrl_reg[wake_pkg::BIT_REMOTE_RX])
    else $error("status dropped");
  chk_irq_follows: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(ctrl_reg[wake_pkg::BIT_REMOTE_RX]) && ctrl_reg[wake_pkg::BIT_IRQ_SEL]
    |-> HOST_IRQ)
    else $error("irq missing");
  chk_event_follows: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(ctrl_reg[wake_pkg::BIT_REMOTE_RX]) && ctrl_reg[wake_pkg::BIT_EVENT_SEL]
    |-> POWER_EVENT_OUT)
    else $error("power event missing");

  // mode and mask checks
  chk_normal_blocked: assert property (@(posedge CLK) disable iff (!RST_N)
    remote_on
    |-> !NORMAL_RX_EN)
    else $error("normal rx during detection");
  chk_pattern_blocks_rx: assert property (@(posedge CLK) disable iff (!RST_N)
    pattern_on
    |-> !NORMAL_RX_EN)
    else $error("normal rx during pattern detection");
  chk_standby_enables: assert property (@(posedge CLK) disable iff (!RST_N)
    STANDBY
    |-> pattern_on && remote_on)
    else $error("standby not detecting");
  chk_resume_rx: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_ctrl && PWDATA[1:0] == 2'b00 && !STANDBY ##1 !STANDBY
    |-> NORMAL_RX_EN)
    else $error("normal rx not resumed");
  chk_mask_top_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    !table_reg[0][31] && !table_reg[1][31] && !table_reg[2][31] && !table_reg[3][31])
    else $error("mask bit 31 set");

  // frame position and scanner checks
  chk_sof_position: assert property (@(posedge CLK) disable iff (!RST_N)
    rx_byte && RX_SOF
    |=> pos_reg == 8'h01)
    else $error("frame position not restarted");
  chk_sof_clears_dest: assert property (@(posedge CLK) disable iff (!RST_N)
    rx_byte && RX_SOF
    |=> !dest_ok_reg)
    else $error("stale destination accepted");
  chk_hit_in_frame: assert property (@(posedge CLK) disable iff (!RST_N)
    remote_hit
    |-> dest_ok_reg && past_hdr && run_len_reg == 7'(RUN_LAST))
    else $error("remote hit out of place");
  // six back-to-back all-ones bytes seen from the hunting state
  sequence sync_run_s;
    (rw_state_reg == wake_pkg::RW_HUNT && scan && is_ff && !RX_EOF)
      ##1 (scan && is_ff && !RX_EOF) [*5];
  endsequence
  chk_sync_to_addr: assert property (@(posedge CLK) disable iff (!RST_N)
    sync_run_s
    |=> rw_state_reg == wake_pkg::RW_ADDR)
    else $error("sync run missed");
  chk_break_restarts: assert property (@(posedge CLK) disable iff (!RST_N)
    rw_state_reg == wake_pkg::RW_ADDR && scan && !RX_EOF && RX_DATA != want_byte && !is_ff
    |=> rw_state_reg == wake_pkg::RW_HUNT)
    else $error("broken run not restarted");
endmodule

// ==== verif/rx_frame_src.sv ====
// receive datapath model that plays byte streams into the detector
`timescale 1ns/1ps
module rx_frame_src (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_sof,
  output logic            rx_eof
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_sof   = 1'b0;
    rx_eof   = 1'b0;
  end
  // gap idles model a slow source; idle data is inverted so stale bytes never look valid
  task automatic send(input logic [7:0] fr[$], input int gap);
    for (int i = 0; i < fr.size(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= fr[i];
      rx_sof   <= (i == 0);
      rx_eof   <= (i == fr.size() - 1);
      for (int g = 0; g < gap; g++) begin
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~fr[i];
      end
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_sof   <= 1'b0;
    rx_eof   <= 1'b0;
    rx_data  <= ~fr[fr.size() - 1];
  endtask
endmodule

// ==== verif/wake_pattern_detector_tb_top.sv ====
// self-checking bench for the wake pattern and remote-wake detector
`timescale 1ns/1ps
module wake_pattern_detector_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        standby = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] lfsr = 32'h180ED0B2;
  logic [31:0] w[8];
  logic [30:0] m;
  logic        pready, pslverr, rx_valid, rx_sof, rx_eof, normal_rx_en, host_irq, power_event_out;
  logic [7:0]  rx_data;
  logic [7:0]  fr[$];
  logic [32:0] notes[$];
  logic [47:0] station = 48'h02A1B2C3D4E5;
  logic [11:0] ctrl = wake_pkg::ADDR_CTRL_STATUS;
  int          errors = 0;
  int          checked = 0;

  always #12.5 clk = ~clk;

  wake_pattern_detector dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_SOF(rx_sof),
    .RX_EOF(rx_eof), .STANDBY(standby), .NORMAL_RX_EN(normal_rx_en), .HOST_IRQ(host_irq),
    .POWER_EVENT_OUT(power_event_out));
  rx_frame_src src (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof),
    .rx_eof(rx_eof));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reference crc over the bytes picked by the mask from the minimum offset
  function automatic logic [15:0] crc_of(input logic [30:0] msk);
    logic [15:0] c;
    c = wake_pkg::CRC16_INIT;
    for (int j = 0; j < 31; j++)
      if (msk[j])
        for (int i = 0; i < 8; i++)
          c = {c[14:0], 1'b0} ^ ((c[15] ^ fr[12 + j][i]) ? wake_pkg::CRC16_POLY : 16'h0000);
    return c;
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checked++;
    if (seen !== want) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] want);
    notes.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic put(input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++)
      for (int b = 5; b >= 0; b--)
        fr.push_back(v[b*8 +: 8]);
  endtask
  task automatic wake_frame(input logic [47:0] dest, input int copies);
    fr = {};
    put(dest, 1);
    put(48'h0A0B0C0D0E0F, 1);
    fr.push_back(8'h33);
    put(48'hFFFFFFFFFFFF, 1);
    put(station, copies);
  endtask
  task automatic tx(input int gap);
    src.send(fr, gap);
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // result watcher: every completed read retires the oldest note
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
      check({pslverr, prdata}, notes.pop_front());

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(ctrl, {1'b0, 32'h00000080});
    rd(12'h030, {1'b1, 32'h0});
    apb(1'b1, wake_pkg::ADDR_STATION_LO, station[31:0]);
    apb(1'b1, wake_pkg::ADDR_STATION_HI, {16'h0000, station[47:32]});
    apb(1'b1, ctrl, 32'h00000012);
    check({32'h0, normal_rx_en}, 33'h0);
    wake_frame(station, 15);
    tx(0);
    wake_frame(48'h02FFEEDDCCBB, 16);
    tx(1);
    rd(ctrl, {1'b0, 32'h00000012});
    wake_frame(station, 3);
    fr.push_back(8'h5A);
    put(48'hFFFFFFFFFFFF, 1);
    put(station, 16);
    tx(0);
    rd(ctrl, {1'b0, 32'h0000001A});
    check({32'h0, host_irq}, 33'h1);
    apb(1'b1, ctrl, 32'h00000018);
    rd(ctrl, {1'b0, 32'h00000090});
    check({31'h0, normal_rx_en, host_irq}, 33'h2);
    apb(1'b1, ctrl, 32'h00000020);
    @(posedge clk) standby <= 1'b1;
    @(negedge clk);
    check({32'h0, normal_rx_en}, 33'h0);
    wake_frame(48'hFFFFFFFFFFFF, 16);
    tx(2);
    rd(ctrl, {1'b0, 32'h00000068});
    check({31'h0, power_event_out, host_irq}, 33'h2);
    @(posedge clk) standby <= 1'b0;
    apb(1'b1, ctrl, 32'h00000008);
    fr = {};
    put(48'h01005E000001, 1);
    put(48'h0A0B0C0D0E0F, 1);
    repeat (40) begin
      lfsr = next_rand(lfsr);
      fr.push_back(lfsr[7:0]);
    end
    lfsr = next_rand(lfsr);
    m = {lfsr[30:1], 1'b1};
    // bit 31 written high on purpose: the mask word must drop it
    w = '{{1'b1, m}, 32'h0, 32'h0, 32'h0, 32'h1, {24'h0, wake_pkg::MIN_OFFSET},
          {16'h0, crc_of(m)}, 32'h0};
    for (int k = 0; k < 8; k++)
      apb(1'b1, wake_pkg::ADDR_FILTER_BASE + 12'(4 * k), w[k]);
    rd(wake_pkg::ADDR_FILTER_BASE, {2'b00, m});
    apb(1'b1, ctrl, 32'h00000011);
    check({32'h0, normal_rx_en}, 33'h0);
    tx(0);
    rd(ctrl, {1'b0, 32'h00000011});
    for (int b = 0; b < 6; b++)
      fr[b] = station[(5 - b)*8 +: 8];
    tx(1);
    rd(ctrl, {1'b0, 32'h00000015});
    check({32'h0, host_irq}, 33'h1);
    apb(1'b1, ctrl, 32'h00000014);
    rd(ctrl, {1'b0, 32'h00000090});
    close_out();
  end

  initial begin
    #500000;
    errors++;
    close_out();
  end
endmodule
